// [src/bca_core.sv]
// apb slave and execution datapath of the byte core alu
// assumes a standard apb master and the file memory beside it
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module bca_core
   import bca_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   // ****************************************
   // functions
   // ****************************************
   // effective address of the indirect access
   function automatic logic [15:0] bca_ea(input logic [15:0] p, input logic [1:0] md,
                                          input logic rel, input logic [5:0] ofs);
      logic [15:0] r;
      r = p;
      if (rel) begin
         r = p + {{10{ofs[5]}}, ofs};
      end else if (md == BCA_PRE_INC) begin
         r = p + BCA_PTR_ONE;
      end else if (md == BCA_PRE_DEC) begin
         r = p - BCA_PTR_ONE;
      end
      return r;
   endfunction
   // pointer value after the access
   function automatic logic [15:0] bca_step(input logic [15:0] p, input logic [1:0] md,
                                            input logic rel);
      logic [15:0] r;
      r = p;
      if (!rel) begin
         r = md[0] ? p - BCA_PTR_ONE : p + BCA_PTR_ONE;
      end
      return r;
   endfunction
   // ****************************************
   // state
   // ****************************************
   bca_state_e state_q; // sequencer state
   logic [31:0] instr_q; // latched instruction word
   logic [7:0] acc_q; // working accumulator
   logic c_q; // carry flag
   logic z_q; // zero flag
   logic [15:0] ptr_q [2]; // the two indirect_pointer registers
   logic rd_ok_q; // file read data valid for this transfer
   bca_mem_if mif ();
   // decoded instruction fields
   bca_op_e op;
   logic dest;
   logic [6:0] faddr;
   logic psel_i;
   logic [1:0] mode;
   logic rel;
   logic [5:0] ofs;
   assign op = bca_op_e'(instr_q[BCA_F_OP +: 3]);
   assign dest = instr_q[BCA_F_DEST];
   assign faddr = instr_q[BCA_F_ADDR +: 7];
   assign psel_i = instr_q[BCA_F_PSEL];
   assign mode = instr_q[BCA_F_MODE +: 2];
   assign rel = instr_q[BCA_F_REL];
   assign ofs = instr_q[BCA_F_OFS +: 6];
   // ****************************************
   // bus decode
   // ****************************************
   logic idle;
   logic hit_mem;
   logic hit_reg;
   logic acc_phase;
   logic wr_go;
   assign idle = (state_q == BCA_ST_IDLE);
   assign hit_mem = ((paddr & BCA_MEM_MASK) == BCA_OFF_MEM);
   assign hit_reg = (paddr == BCA_OFF_INSTR) || (paddr == BCA_OFF_ACC) || (paddr == BCA_OFF_STATUS)
                    || (paddr == BCA_OFF_PTR0) || (paddr == BCA_OFF_PTR1);
   assign acc_phase = psel && penable;
   // stall every access while an op runs; file reads wait for their data
   assign pready = idle && (pwrite || !hit_mem || rd_ok_q);
   assign wr_go = acc_phase && pwrite && pready;
   assign pslverr = acc_phase && !(hit_mem || hit_reg);
   // ****************************************
   // datapath
   // ****************************************
   logic [15:0] ptr_cur; // selected pointer
   logic [15:0] ea; // effective address
   logic is_ind_reg; // file access aimed at an indirect slot
   logic [15:0] ind_ptr; // pointer for an indirect slot
   logic [7:0] src; // fetched operand
   logic [7:0] res; // 8-bit result
   logic res_c; // carry out of shifts
   logic legal; // op code is one we execute
   assign ptr_cur = ptr_q[psel_i];
   assign ea = bca_ea(ptr_cur, mode, rel, ofs);
   assign is_ind_reg = (faddr == BCA_IND0) || (faddr == BCA_IND1);
   assign ind_ptr = ptr_q[faddr == BCA_IND1];
   assign src = mif.rdata;
   // result of the current op
   always_comb begin
      res = src;
      res_c = c_q;
      legal = 1'b1;
      unique case (op)
         BCA_OP_INC: res = src + BCA_BYTE_ONE;
         BCA_OP_IOR: res = acc_q | src;
         BCA_OP_LSL: begin
            res = {src[6:0], 1'b0};
            res_c = src[7];
         end
         BCA_OP_LSR: begin
            res = {1'b0, src[7:1]};
            res_c = src[0];
         end
         BCA_OP_MOV: res = src;
         BCA_OP_IND: res = src;
         default: legal = 1'b0;
      endcase
   end
   // file memory address, write strobe and data
   always_comb begin
      mif.addr = paddr[8:2];
      mif.we = 1'b0;
      mif.wdata = pwdata[7:0];
      if (!idle) begin
         if (op == BCA_OP_IND) begin
            mif.addr = ea[6:0];
         end else if (is_ind_reg) begin
            mif.addr = ind_ptr[6:0];
         end else begin
            mif.addr = faddr;
         end
         mif.we = (state_q == BCA_ST_EXEC) && legal && dest && (op != BCA_OP_IND);
         mif.wdata = res;
      end else begin
         mif.we = wr_go && hit_mem;
      end
   end
   bca_file_mem u_mem (
      .pclk(pclk),
      .m(mif.mem)
   );
   // ****************************************
   // sequencer
   // ****************************************
   // one op: fetch operand, then execute and write back
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= BCA_ST_IDLE;
      end else begin
         unique case (state_q)
            BCA_ST_IDLE: if (wr_go && paddr == BCA_OFF_INSTR) begin
               state_q <= BCA_ST_FETCH;
            end
            BCA_ST_FETCH: state_q <= BCA_ST_EXEC;
            BCA_ST_EXEC: state_q <= BCA_ST_IDLE;
            default: state_q <= BCA_ST_IDLE;
         endcase
      end
   end
   // instruction latch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         instr_q <= '0;
      end else if (idle && wr_go && paddr == BCA_OFF_INSTR) begin
         instr_q <= pwdata;
      end
   end
   // accumulator: op result or software write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_q <= '0;
      end else if (state_q == BCA_ST_EXEC) begin
         if (legal && (!dest || op == BCA_OP_IND)) begin
            acc_q <= res;
         end
      end else if (wr_go && paddr == BCA_OFF_ACC) begin
         acc_q <= pwdata[7:0];
      end
   end
   // flags: zero on every legal op, carry on shifts only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         c_q <= 1'b0;
         z_q <= 1'b0;
      end else if (state_q == BCA_ST_EXEC) begin
         if (legal) begin
            z_q <= (res == BCA_BYTE_ZERO);
         end
         c_q <= res_c;
      end else if (wr_go && paddr == BCA_OFF_STATUS) begin
         c_q <= pwdata[BCA_S_C];
         z_q <= pwdata[BCA_S_Z];
      end
   end
   // pointers: stepped by indirect load, else written by software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ptr_q[0] <= '0;
         ptr_q[1] <= '0;
      end else if (state_q == BCA_ST_EXEC) begin
         if (op == BCA_OP_IND) begin
            ptr_q[psel_i] <= bca_step(ptr_cur, mode, rel);
         end
      end else if (wr_go && paddr == BCA_OFF_PTR0) begin
         ptr_q[0] <= pwdata[15:0];
      end else if (wr_go && paddr == BCA_OFF_PTR1) begin
         ptr_q[1] <= pwdata[15:0];
      end
   end
   // file read data is valid one cycle after the address was presented
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_ok_q <= 1'b0;
      end else begin
         rd_ok_q <= psel && !pwrite && hit_mem && idle && !(penable && pready);
      end
   end
   // read data mux
   always_comb begin
      prdata = '0;
      if (acc_phase && !pwrite) begin
         if (hit_mem) begin
            prdata = {24'h000000, mif.rdata};
         end else if (paddr == BCA_OFF_INSTR) begin
            prdata = instr_q;
         end else if (paddr == BCA_OFF_ACC) begin
            prdata = {24'h000000, acc_q};
         end else if (paddr == BCA_OFF_STATUS) begin
            prdata[BCA_S_C] = c_q;
            prdata[BCA_S_Z] = z_q;
            prdata[BCA_S_BUSY] = !idle;
         end else if (paddr == BCA_OFF_PTR0) begin
            prdata = {16'h0000, ptr_q[0]};
         end else if (paddr == BCA_OFF_PTR1) begin
            prdata = {16'h0000, ptr_q[1]};
         end
      end
   end
   // ****************************************
   // assertions
   // ****************************************
   logic exec;
   assign exec = (state_q == BCA_ST_EXEC);
   sequence s_start;
      idle && wr_go && paddr == BCA_OFF_INSTR;
   endsequence
   sequence s_done;
      state_q == BCA_ST_FETCH ##1 exec ##1 idle;
   endsequence
   a_dest_acc_write: assert property (@(posedge pclk) disable iff (!presetn)
      exec && legal && !dest && op != BCA_OP_IND |=> acc_q == $past(res))
      else $error("acc not loaded for dest 0");
   a_inc_plus_one: assert property (@(posedge pclk) disable iff (!presetn)
      exec && op == BCA_OP_INC && !dest |=> acc_q == $past(src) + BCA_BYTE_ONE && c_q == $past(c_q))
      else $error("increment result or carry wrong");
   a_or_result: assert property (@(posedge pclk) disable iff (!presetn)
      exec && op == BCA_OP_IOR && !dest |=> acc_q == ($past(acc_q) | $past(src)))
      else $error("or result wrong");
   a_lsl_carry: assert property (@(posedge pclk) disable iff (!presetn)
      exec && op == BCA_OP_LSL |=> c_q == $past(src[7]))
      else $error("left shift carry wrong");
   a_lsr_carry: assert property (@(posedge pclk) disable iff (!presetn)
      exec && op == BCA_OP_LSR |=> c_q == $past(src[0]))
      else $error("right shift carry wrong");
   a_mov_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
      s_start ##1 op == BCA_OP_MOV |-> s_done)
      else $error("move did not finish in time");
   a_ptr_step: assert property (@(posedge pclk) disable iff (!presetn)
      exec && op == BCA_OP_IND && !rel |=>
         ptr_q[$past(psel_i)] == $past(ptr_cur) + ($past(mode[0]) ? 16'hffff : BCA_PTR_ONE))
      else $error("pointer step wrong");
   a_ind_no_carry: assert property (@(posedge pclk) disable iff (!presetn)
      exec && op == BCA_OP_IND |=> $stable(c_q))
      else $error("indirect load touched carry");
   a_zero_flag: assert property (@(posedge pclk) disable iff (!presetn)
      exec && legal |=> z_q == ($past(res) == BCA_BYTE_ZERO))
      else $error("zero flag wrong");
   a_rel_address: assert property (@(posedge pclk) disable iff (!presetn)
      exec && op == BCA_OP_IND && rel |-> mif.addr == 7'(ptr_cur + {{10{ofs[5]}}, ofs}))
      else $error("relative address wrong");
   a_ind_reg_addr: assert property (@(posedge pclk) disable iff (!presetn)
      exec && op != BCA_OP_IND && faddr == BCA_IND1 |-> mif.addr == ptr_q[1][6:0])
      else $error("indirect slot not redirected");
   // shift results seen through the accumulator, independent of the result mux
   a_lsl_result: assert property (@(posedge pclk) disable iff (!presetn)
      exec && op == BCA_OP_LSL && !dest |=> acc_q[0] == 1'b0 && acc_q[7:1] == $past(src[6:0]))
      else $error("left shift result wrong");
   a_lsr_result: assert property (@(posedge pclk) disable iff (!presetn)
      exec && op == BCA_OP_LSR && !dest |=> acc_q[7] == 1'b0 && acc_q[6:0] == $past(src[7:1]))
      else $error("right shift result wrong");
   // relative form must leave its pointer where it was
   a_rel_ptr_hold: assert property (@(posedge pclk) disable iff (!presetn)
      exec && op == BCA_OP_IND && rel |=> ptr_q[$past(psel_i)] == $past(ptr_cur))
      else $error("relative load moved the pointer");
   // move doubles as a zero test of the operand
   a_mov_zero_test: assert property (@(posedge pclk) disable iff (!presetn)
      exec && op == BCA_OP_MOV |=> z_q == ($past(src) == BCA_BYTE_ZERO))
      else $error("move zero test wrong");
   // only the shifts may move carry
   a_carry_kept: assert property (@(posedge pclk) disable iff (!presetn)
      exec && op != BCA_OP_LSL && op != BCA_OP_LSR |=> $stable(c_q))
      else $error("carry changed by a non-shift op");
endmodule

// [shared/bca_pkg.sv]
// constants, opcodes and field layout for the byte core alu
// assumes one 50 mhz clock and an apb master on the register side
// How it works
// - 7-bit file address, dest bit picks acc/file
// - increment adds one, touches only zero flag
// - or acc with file, touches only zero
// - left shift: bit7 to carry, zero in
// - right shift: bit0 to carry, zero in
// - move copies file, sets zero flag
// - indirect load via chosen pointer into acc
// - mode 00 pre+,01 pre-,10 post+,11 post-
// - ea is ptr, ptr+1, ptr-1 or ptr+offset
// - pointer steps after load, relative keeps it
// - indirect registers access memory at pointer
// - pointers wrap modulo 65536
// - move finishes in one instruction cycle
// - pointer stepping leaves carry alone
package bca_pkg;
   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam logic [11:0] BCA_OFF_INSTR = 12'h000; // write starts an op
   localparam logic [11:0] BCA_OFF_ACC = 12'h004; // working accumulator
   localparam logic [11:0] BCA_OFF_STATUS = 12'h008; // flags and busy
   localparam logic [11:0] BCA_OFF_PTR0 = 12'h00c; // pointer 0
   localparam logic [11:0] BCA_OFF_PTR1 = 12'h010; // pointer 1
   localparam logic [11:0] BCA_OFF_MEM = 12'h200; // file words, 4 bytes each
   localparam logic [11:0] BCA_MEM_MASK = 12'he00; // selects the file window
   // ****************************************
   // instruction word fields
   // ****************************************
   localparam int BCA_F_OP = 0; // 3-bit opcode
   localparam int BCA_F_DEST = 3; // destination bit
   localparam int BCA_F_ADDR = 4; // 7-bit file address
   localparam int BCA_F_PSEL = 11; // pointer index
   localparam int BCA_F_MODE = 12; // 2-bit pointer_update_mode
   localparam int BCA_F_REL = 14; // relative offset form
   localparam int BCA_F_OFS = 15; // 6-bit signed offset
   // status bits
   localparam int BCA_S_C = 0;
   localparam int BCA_S_Z = 1;
   localparam int BCA_S_BUSY = 2;
   // file addresses of the two indirect_access_register slots
   localparam logic [6:0] BCA_IND0 = 7'h00;
   localparam logic [6:0] BCA_IND1 = 7'h01;
   localparam logic [15:0] BCA_PTR_ONE = 16'h0001;
   localparam logic [7:0] BCA_BYTE_ONE = 8'h01;
   localparam logic [7:0] BCA_BYTE_ZERO = 8'h00;
   // ****************************************
   // types
   // ****************************************
   typedef enum logic [2:0] {
      BCA_OP_INC = 3'b000, // increment_register_op
      BCA_OP_IOR = 3'b001, // or_accumulator_with_register_op
      BCA_OP_LSL = 3'b010, // logical_shift_left_op
      BCA_OP_LSR = 3'b011, // logical_shift_right_op
      BCA_OP_MOV = 3'b100, // move_register_op
      BCA_OP_IND = 3'b101  // indirect_load_op
   } bca_op_e;
   typedef enum logic [1:0] {
      BCA_PRE_INC = 2'b00,
      BCA_PRE_DEC = 2'b01,
      BCA_POST_INC = 2'b10,
      BCA_POST_DEC = 2'b11
   } bca_mode_e;
   typedef enum logic [1:0] {
      BCA_ST_IDLE = 2'b00,
      BCA_ST_FETCH = 2'b01,
      BCA_ST_EXEC = 2'b10
   } bca_state_e;
endpackage

// [shared/bca_mem_if.sv]
// port group between the alu core and its file memory
// assumes both ends share the core clock
`timescale 1ns/1ps
interface bca_mem_if;
   logic [6:0] addr; // word address
   logic we; // write strobe
   logic [7:0] wdata; // write data
   logic [7:0] rdata; // registered read data
   modport core (output addr, output we, output wdata, input rdata);
   modport mem (input addr, input we, input wdata, output rdata);
endinterface

// [src/bca_file_mem.sv]
// 128 x 8 file memory with registered read
// assumes the core drives address and strobe on pclk
`timescale 1ns/1ps
module bca_file_mem (
   input wire logic pclk,
   bca_mem_if.mem m
);
   // storage, no reset on contents
   logic [7:0] mem_q [128];
   // write and registered read
   always_ff @(posedge pclk) begin
      if (m.we) begin
         mem_q[m.addr] <= m.wdata;
      end
      m.rdata <= mem_q[m.addr];
   end
endmodule

// [tb/bca_apb_mst.sv]
// apb master model standing in for the instruction source of the alu
// assumes a free running pclk and a slave that answers with pready
`timescale 1ns/1ps
module bca_apb_mst (
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // ****************************************
   // idle bus
   // ****************************************
   // nothing requested at time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
   end
   // ****************************************
   // one transfer
   // ****************************************
   // setup cycle, then access held until pready is seen at an edge
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // wait states: the request stays untouched meanwhile
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      // release, and scramble lines so stale values are not trusted
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule

// [tb/tb.sv]
// self-checking bench for the byte core alu
// assumes bca_core with its file memory inside, reached over apb
`timescale 1ns/1ps
`define CHK(got, exp) begin \
   tests_run++; \
   if ((got) !== (exp)) begin \
      failures++; \
      $display("mismatch at %0t got %h expected %h", $time, (got), (exp)); \
   end \
end
module tb;
   import bca_pkg::*;
   logic pclk; // 50 mhz core clock
   logic presetn; // active low reset
   logic psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [31:0] rd_data; // last data returned
   logic rd_err; // last slave error
   int failures, tests_run;
   int cyc = 0; // clock cycles since start
   bca_core u_bca_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   bca_apb_mst u_bca_apb_mst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   // ****************************************
   // clock, timeout, verdict
   // ****************************************
   always #10 pclk = ~pclk;
   // a hang counts as a mismatch
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("compares %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // ****************************************
   // helpers
   // ****************************************
   // byte address of a file word
   function automatic logic [11:0] fa(input logic [6:0] f);
      return BCA_OFF_MEM + {3'b000, f, 2'b00};
   endfunction
   // instruction word from its fields
   function automatic logic [31:0] ins(input logic [2:0] op, input logic d, input logic [6:0] f,
      input logic p, input logic [1:0] m, input logic rel, input logic [5:0] o);
      ins = 32'h0000_0000;
      ins[BCA_F_OP +: 3] = op;
      ins[BCA_F_DEST] = d;
      ins[BCA_F_ADDR +: 7] = f;
      ins[BCA_F_PSEL] = p;
      ins[BCA_F_MODE +: 2] = m;
      ins[BCA_F_REL] = rel;
      ins[BCA_F_OFS +: 6] = o;
   endfunction
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      u_bca_apb_mst.xfer(1'b1, a, d, rd_data, rd_err);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      u_bca_apb_mst.xfer(1'b0, a, 32'h0000_0000, rd_data, rd_err);
      `CHK(rd_data, exp)
   endtask
   // file op with flags preset opposite to the expected zero flag
   task automatic fop(input logic [2:0] op, input logic d, input logic [6:0] f,
      input logic [7:0] a0, input logic [7:0] fv, input logic [7:0] res, input logic c0, input logic c1);
      logic z;
      z = (res == 8'h00);
      wr(BCA_OFF_ACC, {24'h000000, a0});
      wr(fa(f), {24'h000000, fv});
      wr(BCA_OFF_STATUS, {30'h0, ~z, c0});
      wr(BCA_OFF_INSTR, ins(op, d, f, 1'b0, 2'b00, 1'b0, 6'h00));
      rdc(BCA_OFF_ACC, {24'h000000, d ? a0 : res});
      rdc(fa(f), {24'h000000, d ? res : fv});
      rdc(BCA_OFF_STATUS, {30'h0, z, c1});
   endtask
   // indirect load: pointer p0 in, data v at ea, pointer p1 after
   task automatic ind(input logic p, input logic [1:0] m, input logic rel, input logic [5:0] o,
      input logic [15:0] p0, input logic [15:0] ea, input logic [15:0] p1, input logic [7:0] v);
      logic [11:0] pa;
      pa = p ? BCA_OFF_PTR1 : BCA_OFF_PTR0;
      wr(pa, {16'h0000, p0});
      wr(fa(ea[6:0]), {24'h000000, v});
      wr(BCA_OFF_STATUS, {30'h0, v != 8'h00, v[0]});
      wr(BCA_OFF_ACC, {24'h000000, ~v});
      wr(BCA_OFF_INSTR, ins(BCA_OP_IND, 1'b1, 7'h00, p, m, rel, o));
      rdc(BCA_OFF_ACC, {24'h000000, v});
      rdc(pa, {16'h0000, p1});
      rdc(BCA_OFF_STATUS, {30'h0, v == 8'h00, v[0]});
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   // reset values and an unmapped read
   task automatic t_reset();
      rdc(BCA_OFF_ACC, 32'h0000_0000);
      rdc(BCA_OFF_STATUS, 32'h0000_0000);
      rdc(BCA_OFF_PTR0, 32'h0000_0000);
      rdc(BCA_OFF_PTR1, 32'h0000_0000);
      rdc(12'h100, 32'h0000_0000);
      `CHK(rd_err, 1'b1)
      $display("test reset done");
   endtask
   // every file op, both destinations
   task automatic t_alu();
      fop(BCA_OP_INC, 1'b1, 7'h05, 8'h3c, 8'hff, 8'h00, 1'b1, 1'b1);
      fop(BCA_OP_INC, 1'b0, 7'h06, 8'h00, 8'h41, 8'h42, 1'b0, 1'b0);
      fop(BCA_OP_IOR, 1'b0, 7'h07, 8'h0f, 8'ha0, 8'haf, 1'b1, 1'b1);
      fop(BCA_OP_IOR, 1'b1, 7'h08, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0);
      fop(BCA_OP_LSL, 1'b1, 7'h09, 8'h00, 8'h81, 8'h02, 1'b0, 1'b1);
      fop(BCA_OP_LSL, 1'b0, 7'h0a, 8'h11, 8'h40, 8'h80, 1'b1, 1'b0);
      fop(BCA_OP_LSR, 1'b0, 7'h0b, 8'h22, 8'h01, 8'h00, 1'b0, 1'b1);
      fop(BCA_OP_LSR, 1'b1, 7'h0c, 8'h00, 8'hfe, 8'h7f, 1'b1, 1'b0);
      fop(BCA_OP_MOV, 1'b1, 7'h7f, 8'h12, 8'h00, 8'h00, 1'b1, 1'b1);
      fop(BCA_OP_MOV, 1'b0, 7'h0d, 8'h00, 8'h5a, 8'h5a, 1'b0, 1'b0);
      $display("test alu done");
   endtask
   // all pointer modes, wrap both ways, offset limits
   task automatic t_ind();
      ind(1'b0, 2'b00, 1'b0, 6'h00, 16'h1233, 16'h1234, 16'h1234, 8'h9e);
      ind(1'b1, 2'b01, 1'b0, 6'h00, 16'h0050, 16'h004f, 16'h004f, 8'h00);
      ind(1'b0, 2'b10, 1'b0, 6'h00, 16'h0020, 16'h0020, 16'h0021, 8'h5c);
      ind(1'b1, 2'b11, 1'b0, 6'h00, 16'h0033, 16'h0033, 16'h0032, 8'h71);
      ind(1'b0, 2'b10, 1'b0, 6'h00, 16'hffff, 16'hffff, 16'h0000, 8'h17);
      ind(1'b1, 2'b01, 1'b0, 6'h00, 16'h0000, 16'hffff, 16'hffff, 8'h28);
      ind(1'b0, 2'b11, 1'b1, 6'h20, 16'h0140, 16'h0120, 16'h0140, 8'h3a);
      ind(1'b1, 2'b00, 1'b1, 6'h1f, 16'h0140, 16'h015f, 16'h0140, 8'h4b);
      $display("test indirect done");
   endtask
   // plain ops on the indirect slots, and op latency
   task automatic t_slot();
      time t0;
      wr(BCA_OFF_PTR0, 32'h0000_0025);
      wr(fa(7'h25), 32'h0000_0066);
      wr(BCA_OFF_PTR1, 32'h0000_0026);
      wr(fa(7'h26), 32'h0000_0010);
      wr(BCA_OFF_INSTR, ins(BCA_OP_MOV, 1'b0, BCA_IND0, 1'b0, 2'b00, 1'b0, 6'h00));
      t0 = $time;
      rdc(BCA_OFF_ACC, 32'h0000_0066);
      `CHK(32'(($time - t0) / 20), 32'd3)
      wr(BCA_OFF_INSTR, ins(BCA_OP_INC, 1'b1, BCA_IND1, 1'b0, 2'b00, 1'b0, 6'h00));
      rdc(fa(7'h26), 32'h0000_0011);
      rdc(BCA_OFF_PTR1, 32'h0000_0026);
      // an unused op code runs its cycles and changes nothing
      wr(BCA_OFF_INSTR, ins(3'b110, 1'b1, 7'h0d, 1'b0, 2'b00, 1'b0, 6'h00));
      rdc(BCA_OFF_INSTR, ins(3'b110, 1'b1, 7'h0d, 1'b0, 2'b00, 1'b0, 6'h00));
      rdc(BCA_OFF_ACC, 32'h0000_0066);
      rdc(fa(7'h0d), 32'h0000_005a);
      rdc(BCA_OFF_STATUS, 32'h0000_0001);
      $display("test slot done");
   endtask
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      failures = 0;
      tests_run = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_alu();
      t_ind();
      t_slot();
      print_verdict();
   end
endmodule
